/* File: logic/gpio_ports_pkg.sv */
// Shared constants and types for the port G/H/J data-register block
package gpio_ports_pkg;

  localparam int          ADDR_W      = 32;
  localparam int          DATA_W      = 8;
  localparam int          PORT_W      = 8;
  localparam int          MODE_W      = 2;
  localparam int          SYNC_STAGES = 3;

  // Register offsets as printed; the top three address bits only pick a space alias
  localparam logic [31:0] OFS_G_DATA  = 32'h0400012c;
  localparam logic [31:0] OFS_H_DATA  = 32'h0400012e;
  localparam logic [31:0] OFS_J_DATA  = 32'ha4000130;
  localparam logic [31:0] PHYS_MASK   = 32'h1fffffff;

  // Field positions and values after power-on reset
  localparam int          H_RW_BIT    = 7;
  localparam logic        RST_H_BIT7  = 1'b0;
  localparam logic [7:0]  RST_J_DATA  = 8'h00;
  localparam logic [7:0]  RD_IDLE     = 8'h00;
  localparam logic        RST_SYNC    = 1'b0;

  typedef enum logic [1:0] {
    MODE_OTHER     = 2'b00,
    MODE_OUTPUT    = 2'b01,
    MODE_IN_PULLUP = 2'b10,
    MODE_IN_NOPULL = 2'b11
  } pin_mode_type;

endpackage

/* File: logic/pin_sync_if.sv */
// Carrier between the register block and its pin synchroniser bank
`timescale 1ns/1ps
interface pin_sync_if #(
  parameter int WIDTH = 24
);
  logic [WIDTH-1:0] raw;
  logic [WIDTH-1:0] clean;

  modport user (output raw, input clean);
  modport sync (input raw, output clean);
endinterface

/* File: logic/pin_sync_bank.sv */
// Three-stage pin synchroniser with agreement filter, one lane per pin
`timescale 1ns/1ps
module pin_sync_bank #(
  parameter int WIDTH = 24
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  // Pins in, settled levels out
  pin_sync_if.sync  pins
);

  if (WIDTH < 1) begin : badWidth
    $error("pin_sync_bank needs at least one lane");
  end
  if (gpio_ports_pkg::SYNC_STAGES != 3) begin : badStages
    $error("pin_sync_bank is built for three stages");
  end

  for (genvar i = 0; i < WIDTH; i++) begin : lane
    logic stage1_r;
    logic stage2_r;
    logic stage3_r;
    logic settled_r;

    // First stage feeds only the second, never any logic
    always_ff @(posedge clock) begin
      if (!rst_n) begin
        stage1_r <= gpio_ports_pkg::RST_SYNC;
        stage2_r <= gpio_ports_pkg::RST_SYNC;
        stage3_r <= gpio_ports_pkg::RST_SYNC;
      end else begin
        stage1_r <= pins.raw[i];
        stage2_r <= stage1_r;
        stage3_r <= stage2_r;
      end
    end

    // A change counts only once two later stages agree, so a runt is dropped
    always_ff @(posedge clock) begin
      if (!rst_n) begin
        settled_r <= gpio_ports_pkg::RST_SYNC;
      end else if (stage2_r == stage3_r) begin
        settled_r <= stage3_r; // [R15]
      end
    end

    assign pins.clean[i] = settled_r;
  end

endmodule

/* File: logic/gpio_ports_g_h_j.sv */
// Data registers and pin logic for general-purpose ports G, H and J
// What this block does
// [R1] Port G data register is 8-bit read-only, bit n mirrors pin n.
// [R2] A port G pin in general input mode reads its current level.
// [R3] After power-on reset port G pins are inputs with pull-up; reads give pins.
// [R4] Writes to read-only bits (all G, H bits 6..0) are dropped, pins untouched.
// [R5] Port H bit 7 is read/write, bits 6..0 read-only, each mirrors its pin.
// [R6] Power-on reset clears H bit 7; H pins start as pulled-up inputs.
// [R7] Port H contents survive standby, sleep and manual reset.
// [R8] Port H bits 6..0 read low unless their pin is a general input.
// [R9] A writable bit whose pin is an output reads back the stored bit.
// [R10] In output mode the stored writable bit drives its pin.
// [R11] Other-function and input modes still store writes but leave the pin alone.
// [R12] Mode 00 other function, 01 output/reserved, 10 pull-up input, 11 plain input.
// [R13] Port J data register is 8-bit read/write, cleared by power-on reset.
// [R14] Port J contents survive standby, sleep and manual reset.
// [R15] Every input pin passes a synchroniser before a register read sees it.
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
module gpio_ports_g_h_j #(
  parameter int PORT_W = gpio_ports_pkg::PORT_W
) (
  // Clock and power-on reset
  input  wire logic                  clock,
  input  wire logic                  rst_n,
  // Register port
  input  wire logic [31:0]           addr,
  input  wire logic [7:0]            wrData,
  input  wire logic                  wrStrobe,
  input  wire logic                  rdStrobe,
  output logic      [7:0]            rdData,
  // Pin mode fields, two bits per pin, pin n at bits 2n+1:2n
  input  wire logic [2*PORT_W-1:0]   gMode,
  input  wire logic [2*PORT_W-1:0]   hMode,
  input  wire logic [2*PORT_W-1:0]   jMode,
  // Port G pins
  input  wire logic [PORT_W-1:0]     gPinIn,
  output logic      [PORT_W-1:0]     gPullUp,
  // Port H pins
  input  wire logic [PORT_W-1:0]     hPinIn,
  output logic                       hPin7Out,
  output logic                       hPin7OeN,
  output logic      [PORT_W-1:0]     hPullUp,
  // Port J pins
  input  wire logic [PORT_W-1:0]     jPinIn,
  output logic      [PORT_W-1:0]     jPinOut,
  output logic      [PORT_W-1:0]     jPinOeN,
  output logic      [PORT_W-1:0]     jPullUp
);

  localparam int SYNC_W = 3 * PORT_W;

  if (PORT_W != gpio_ports_pkg::DATA_W) begin : badWidth
    $error("gpio_ports_g_h_j ports must match the 8-bit data path");
  end

  logic                hBit7_r;
  logic [PORT_W-1:0]   jData_r;
  logic [7:0]          rdData_r;
  logic [PORT_W-1:0]   gSync;
  logic [PORT_W-1:0]   hSync;
  logic [PORT_W-1:0]   jSync;
  logic [PORT_W-1:0]   gRead;
  logic [PORT_W-1:0]   hRead;
  logic [PORT_W-1:0]   jRead;
  logic [31:0]         physAddr;
  logic                hitG;
  logic                hitH;
  logic                hitJ;
  logic [7:0]          rdData_nxt;
  logic                hWrEn;
  logic                jWrEn;

  // Which register an access names; the hits are exclusive so order is free
  typedef enum logic [1:0] {
    SEL_NONE = 2'b00,
    SEL_G    = 2'b01,
    SEL_H    = 2'b10,
    SEL_J    = 2'b11
  } reg_sel_type;

  reg_sel_type         regSel;

  pin_sync_if #(.WIDTH(SYNC_W)) syncBus ();

  // Pins cross into the clock domain before any read sees them
  assign syncBus.raw = {jPinIn, hPinIn, gPinIn}; // [R15]
  assign gSync       = syncBus.clean[PORT_W-1:0];
  assign hSync       = syncBus.clean[2*PORT_W-1:PORT_W];
  assign jSync       = syncBus.clean[3*PORT_W-1:2*PORT_W];

  pin_sync_bank #(.WIDTH(SYNC_W)) pinSync (
    .clock (clock),
    .rst_n (rst_n),
    .pins  (syncBus)
  );

  // Address decode; the alias bits are ignored so both address spaces hit
  assign physAddr = addr & gpio_ports_pkg::PHYS_MASK;
  assign hitG     = physAddr == (gpio_ports_pkg::OFS_G_DATA & gpio_ports_pkg::PHYS_MASK);
  assign hitH     = physAddr == (gpio_ports_pkg::OFS_H_DATA & gpio_ports_pkg::PHYS_MASK);
  assign hitJ     = physAddr == (gpio_ports_pkg::OFS_J_DATA & gpio_ports_pkg::PHYS_MASK);

  always_comb begin
    regSel = SEL_NONE;
    if (hitG) begin
      regSel = SEL_G;
    end else if (hitH) begin
      regSel = SEL_H;
    end else if (hitJ) begin
      regSel = SEL_J;
    end
  end

  // A write strobe to port G or an unmapped address reaches no storage
  assign hWrEn = wrStrobe && (regSel == SEL_H);
  assign jWrEn = wrStrobe && (regSel == SEL_J);

  // Per-pin decode; each port keeps its own tables since the rules differ by bit
  for (genvar i = 0; i < PORT_W; i++) begin : pinBit
    // Only port H bit 7 holds storage; its lower bits are input-only
    localparam bit H_WR = i == gpio_ports_pkg::H_RW_BIT;

    gpio_ports_pkg::pin_mode_type gM;
    gpio_ports_pkg::pin_mode_type hM;
    gpio_ports_pkg::pin_mode_type jM;
    logic                         gRdBit;
    logic                         gPullBit;
    logic                         hRdBit;
    logic                         hPullBit;
    logic                         jRdBit;
    logic                         jPullBit;
    logic                         jOeNBit;

    assign gM = gpio_ports_pkg::pin_mode_type'(gMode[2*i+:2]);
    assign hM = gpio_ports_pkg::pin_mode_type'(hMode[2*i+:2]);
    assign jM = gpio_ports_pkg::pin_mode_type'(jMode[2*i+:2]);

    // Port G read: level in either input mode, low in 00 and the reserved 01
    always_comb begin
      gRdBit = 1'h0;
      case (gM)
        gpio_ports_pkg::MODE_OTHER: begin
          gRdBit = 1'h0; // [R12]
        end
        gpio_ports_pkg::MODE_OUTPUT: begin
          gRdBit = 1'h0; // [R12]
        end
        gpio_ports_pkg::MODE_IN_PULLUP: begin
          gRdBit = gSync[i]; // [R1] [R2]
        end
        gpio_ports_pkg::MODE_IN_NOPULL: begin
          gRdBit = gSync[i]; // [R1] [R2]
        end
        default: begin
          gRdBit = 1'h0;
        end
      endcase
    end

    // Port G pad: never driven; the controller resets to 10, hence pulled-up inputs
    always_comb begin
      gPullBit = 1'h0;
      case (gM)
        gpio_ports_pkg::MODE_IN_PULLUP: begin
          gPullBit = 1'h1; // [R3]
        end
        gpio_ports_pkg::MODE_OTHER,
        gpio_ports_pkg::MODE_OUTPUT,
        gpio_ports_pkg::MODE_IN_NOPULL: begin
          gPullBit = 1'h0; // [R12]
        end
        default: begin
          gPullBit = 1'h0;
        end
      endcase
    end

    // Port H read: pin level in input modes, else stored bit 7 or low
    always_comb begin
      hRdBit = 1'h0;
      case (hM)
        gpio_ports_pkg::MODE_OTHER: begin
          hRdBit = H_WR ? hBit7_r : 1'h0; // [R8]
        end
        gpio_ports_pkg::MODE_OUTPUT: begin
          hRdBit = H_WR ? hBit7_r : 1'h0; // [R8] [R9]
        end
        gpio_ports_pkg::MODE_IN_PULLUP: begin
          hRdBit = hSync[i]; // [R5]
        end
        gpio_ports_pkg::MODE_IN_NOPULL: begin
          hRdBit = hSync[i]; // [R5]
        end
        default: begin
          hRdBit = 1'h0;
        end
      endcase
    end

    // Port H pad: pull-up only in mode 10; the bit 7 driver is decoded below
    always_comb begin
      hPullBit = 1'h0;
      case (hM)
        gpio_ports_pkg::MODE_IN_PULLUP: begin
          hPullBit = 1'h1; // [R6]
        end
        gpio_ports_pkg::MODE_OTHER,
        gpio_ports_pkg::MODE_OUTPUT,
        gpio_ports_pkg::MODE_IN_NOPULL: begin
          hPullBit = 1'h0; // [R12]
        end
        default: begin
          hPullBit = 1'h0;
        end
      endcase
    end

    // Port J read: stored bit unless an input mode selects the pin level
    always_comb begin
      jRdBit = jData_r[i];
      case (jM)
        gpio_ports_pkg::MODE_OTHER: begin
          jRdBit = jData_r[i]; // [R11]
        end
        gpio_ports_pkg::MODE_OUTPUT: begin
          jRdBit = jData_r[i]; // [R9]
        end
        gpio_ports_pkg::MODE_IN_PULLUP: begin
          jRdBit = jSync[i]; // [R12]
        end
        gpio_ports_pkg::MODE_IN_NOPULL: begin
          jRdBit = jSync[i]; // [R12]
        end
        default: begin
          jRdBit = jData_r[i];
        end
      endcase
    end

    // Port J pad: driven only in mode 01, so a stored write never leaks out early
    always_comb begin
      jOeNBit  = 1'h1;
      jPullBit = 1'h0;
      case (jM)
        gpio_ports_pkg::MODE_OUTPUT: begin
          jOeNBit = 1'h0; // [R10]
        end
        gpio_ports_pkg::MODE_IN_PULLUP: begin
          jPullBit = 1'h1; // [R11] [R12]
        end
        gpio_ports_pkg::MODE_OTHER,
        gpio_ports_pkg::MODE_IN_NOPULL: begin
          jOeNBit = 1'h1; // [R11]
        end
        default: begin
          jOeNBit = 1'h1;
        end
      endcase
    end

    assign gRead[i]   = gRdBit;
    assign gPullUp[i] = gPullBit;
    assign hRead[i]   = hRdBit;
    assign hPullUp[i] = hPullBit;
    assign jRead[i]   = jRdBit;
    assign jPullUp[i] = jPullBit;
    assign jPinOeN[i] = jOeNBit;
  end

  // Port H bit 7 pin driver
  assign hPin7OeN = gpio_ports_pkg::pin_mode_type'(hMode[2*gpio_ports_pkg::H_RW_BIT+:2])
                    != gpio_ports_pkg::MODE_OUTPUT; // [R10] [R11]
  assign hPin7Out = hBit7_r; // [R10]
  assign jPinOut  = jData_r; // [R10]

  // Only rst_n clears these; low-power modes and manual reset never reach here
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      hBit7_r <= gpio_ports_pkg::RST_H_BIT7; // [R6] [R7]
    end else if (hWrEn) begin
      // Bits 6..0 of the write are dropped, whatever the mode
      hBit7_r <= wrData[gpio_ports_pkg::H_RW_BIT]; // [R4] [R5] [R11]
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      jData_r <= gpio_ports_pkg::RST_J_DATA; // [R13] [R14]
    end else if (jWrEn) begin
      jData_r <= wrData; // [R11] [R13]
    end
  end

  // Port G holds no storage, so a write to it has nothing to change
  always_comb begin
    rdData_nxt = gpio_ports_pkg::RD_IDLE;
    if (rdStrobe) begin
      case (regSel)
        SEL_G: begin
          rdData_nxt = gRead; // [R1] [R4]
        end
        SEL_H: begin
          rdData_nxt = hRead; // [R5]
        end
        SEL_J: begin
          rdData_nxt = jRead; // [R13]
        end
        default: begin
          rdData_nxt = gpio_ports_pkg::RD_IDLE;
        end
      endcase
    end
  end

  // Read data stand for exactly one cycle after the strobe, zero otherwise
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rdData_r <= gpio_ports_pkg::RD_IDLE;
    end else begin
      rdData_r <= rdData_nxt;
    end
  end

  assign rdData = rdData_r;

endmodule

/* File: dv/gpio_ports_g_h_j_monitor.sv */
// Assertion checker for the port G/H/J register block
`timescale 1ns/1ps
module gpio_ports_g_h_j_monitor #(
  parameter int PORT_W = 8
) (
  // Clock and reset
  input wire logic                clock,
  input wire logic                rst_n,
  // Register port
  input wire logic [31:0]         addr,
  input wire logic [7:0]          wrData,
  input wire logic                wrStrobe,
  input wire logic                rdStrobe,
  input wire logic [7:0]          rdData,
  // Modes and pin outputs
  input wire logic [2*PORT_W-1:0] gMode,
  input wire logic [2*PORT_W-1:0] hMode,
  input wire logic [2*PORT_W-1:0] jMode,
  input wire logic [PORT_W-1:0]   gPullUp,
  input wire logic                hPin7Out,
  input wire logic                hPin7OeN,
  input wire logic [PORT_W-1:0]   jPinOut,
  input wire logic [PORT_W-1:0]   jPinOeN
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic hitG;
  logic hitH;
  logic hitJ;
  // Upper three address bits only alias, so decode the masked address
  assign hitG = (addr & 32'h1fffffff) == 32'h0400012c;
  assign hitH = (addr & 32'h1fffffff) == 32'h0400012e;
  assign hitJ = (addr & 32'h1fffffff) == 32'h04000130;
  AST_J_WRITE: assert property (wrStrobe && hitJ |=> jPinOut == $past(wrData))
    else $error("port J write not stored");
  AST_J_HOLD: assert property (!(wrStrobe && hitJ) |=> $stable(jPinOut))
    else $error("port J changed without write");
  AST_H7_WRITE: assert property (wrStrobe && hitH |=> hPin7Out == $past(wrData[7]))
    else $error("port H bit 7 write not stored");
  AST_H7_HOLD: assert property (!(wrStrobe && hitH) |=> $stable(hPin7Out))
    else $error("port H bit 7 changed without write");
  AST_G_WRITE: assert property (wrStrobe && hitG |=> $stable(jPinOut) && $stable(hPin7Out))
    else $error("port G write disturbed stored bits");
  AST_OEN_J: assert property (jPinOeN[0] == (jMode[1:0] != 2'b01))
    else $error("port J pin 0 enable wrong");
  AST_OEN_H: assert property (hPin7OeN == (hMode[15:14] != 2'b01))
    else $error("port H pin 7 enable wrong");
  AST_PULL_G: assert property (gPullUp[7] == (gMode[15:14] == 2'b10))
    else $error("port G pin 7 pull-up wrong");
  AST_J_READ: assert property (rdStrobe && hitJ && jMode == 16'h5555 |=> rdData == jPinOut)
    else $error("port J output read not stored value");
  AST_H_LOW: assert property (rdStrobe && hitH && !hMode[1] |=> !rdData[0])
    else $error("port H bit 0 not low");
endmodule
bind gpio_ports_g_h_j gpio_ports_g_h_j_monitor #(.PORT_W(PORT_W)) mon (.clock(clock),
  .rst_n(rst_n), .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe),
  .rdData(rdData), .gMode(gMode), .hMode(hMode), .jMode(jMode), .gPullUp(gPullUp),
  .hPin7Out(hPin7Out), .hPin7OeN(hPin7OeN), .jPinOut(jPinOut), .jPinOeN(jPinOeN));

/* File: dv/pin_board_model.sv */
// Board-side model of the port pins: drivers, pull-ups and floating lines
`timescale 1ns/1ps
module pin_board_model (
  // Clock
  input  wire logic       clock,
  // Board levels and drive enables
  input  wire logic [7:0] boardEn,
  input  wire logic [7:0] gVal,
  input  wire logic [7:0] hVal,
  input  wire logic [7:0] jVal,
  // Device side
  input  wire logic [7:0] gPullUp,
  input  wire logic [7:0] jPullUp,
  input  wire logic       hPin7Out,
  input  wire logic       hPin7OeN,
  input  wire logic [7:0] jPinOut,
  input  wire logic [7:0] jPinOeN,
  // Resolved pin levels
  output logic      [7:0] gPin,
  output logic      [7:0] hPin,
  output logic      [7:0] jPin
);
  logic       tog;
  logic [7:0] jBrd;
  // A floating pin without pull-up toggles every clock, so the agreement filter keeps its last settled level
  initial tog = 1'b0;
  always @(posedge clock) tog <= ~tog;
  assign gPin = (boardEn & gVal) | (~boardEn & (gPullUp | {8{tog}}));
  assign jBrd = (boardEn & jVal) | (~boardEn & (jPullUp | {8{tog}}));
  assign hPin = {hPin7OeN ? hVal[7] : hPin7Out, hVal[6:0]};
  assign jPin = (~jPinOeN & jPinOut) | (jPinOeN & jBrd);
endmodule

/* File: dv/gpio_ports_g_h_j_tb_top.sv */
// Self-checking bench for the port G/H/J register block
`timescale 1ns/1ps
module gpio_ports_g_h_j_tb_top;
  localparam logic [31:0] AG = 32'h0400012c;
  localparam logic [31:0] AH = 32'ha400012e;
  localparam logic [31:0] AJ = 32'ha4000130;
  logic        clock, rst_n, wrStrobe, rdStrobe, hPin7Out, hPin7OeN;
  logic [31:0] addr;
  logic [15:0] gMode, hMode, jMode;
  logic [7:0]  wrData, rdData, gPin, hPin, jPin, gPullUp, hPullUp, jPullUp, jPinOut, jPinOeN;
  logic [7:0]  boardEn, gVal, hVal, jVal;
  int          nFail, nTests;
  gpio_ports_g_h_j gpio_ports_g_h_j_inst (.clock(clock), .rst_n(rst_n), .addr(addr),
    .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData),
    .gMode(gMode), .hMode(hMode), .jMode(jMode), .gPinIn(gPin), .gPullUp(gPullUp),
    .hPinIn(hPin), .hPin7Out(hPin7Out), .hPin7OeN(hPin7OeN), .hPullUp(hPullUp), .jPinIn(jPin),
    .jPinOut(jPinOut), .jPinOeN(jPinOeN), .jPullUp(jPullUp));
  pin_board_model pin_board_model_inst (.clock(clock), .boardEn(boardEn), .gVal(gVal),
    .hVal(hVal), .jVal(jVal), .gPullUp(gPullUp), .jPullUp(jPullUp), .hPin7Out(hPin7Out),
    .hPin7OeN(hPin7OeN), .jPinOut(jPinOut), .jPinOeN(jPinOeN), .gPin(gPin), .hPin(hPin),
    .jPin(jPin));
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    nTests++;
    if (got !== exp) begin
      nFail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wrData <= d;
    wrStrobe <= 1'b1;
    @(posedge clock);
    wrStrobe <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, input logic [7:0] exp);
    @(posedge clock);
    addr <= a;
    rdStrobe <= 1'b1;
    @(posedge clock);
    rdStrobe <= 1'b0;
    @(negedge clock);
    chk("rdData", exp, rdData);
  endtask
  // Synchroniser needs about four edges, so settle six after a mode change
  task automatic setMode(input logic [1:0] m);
    @(posedge clock);
    gMode <= {8{m}};
    hMode <= {8{m}};
    jMode <= {8{m}};
    repeat (6) @(posedge clock);
  endtask
  task automatic finalReport;
    $display("Checks %0d mismatches %0d", nTests, nFail);
    if (nFail == 0 && nTests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clock);
    nFail++;
    finalReport;
  end
  initial begin
    {rst_n, wrStrobe, rdStrobe, addr, wrData} = '0;
    {gMode, hMode, jMode} = {3{16'haaaa}};
    {boardEn, gVal, hVal, jVal} = 32'hffa53c96;
    {nFail, nTests} = '0;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    repeat (6) @(posedge clock);
    rd(AG, 8'ha5);
    rd(AH, 8'h3c);
    rd(AJ, 8'h96);
    chk("jPinOut", 8'h00, jPinOut);
    $display("Test reset defaults done");
    wr(AG, 8'hff);
    wr(AH, 8'hff);
    wr(AJ, 8'h0f);
    rd(AG, 8'ha5);
    rd(AH, 8'h3c);
    chk("hPin7OeN", 8'h01, {7'h0, hPin7OeN});
    $display("Test input-mode writes done");
    for (int m = 0; m < 4; m++) begin
      setMode(m[1:0]);
      rd(AG, m[1] ? 8'ha5 : 8'h00);
      rd(AH, m[1] ? 8'h3c : 8'h80);
      rd(AJ, m[1] ? 8'h96 : 8'h0f);
      chk("jPinOeN", m == 1 ? 8'h00 : 8'hff, jPinOeN);
      chk("jPullUp", m == 2 ? 8'hff : 8'h00, jPullUp);
      chk("jPin", m == 1 ? 8'h0f : 8'h96, jPin);
      chk("gPullUp", m == 2 ? 8'hff : 8'h00, gPullUp);
      chk("hPullUp", m == 2 ? 8'hff : 8'h00, hPullUp);
      chk("hPin7Out", 8'h01, {7'h0, hPin7Out});
    end
    $display("Test mode table done");
    setMode(2'b01);
    wr(AJ, 8'h5a);
    wr(AH, 8'h00);
    repeat (50) @(posedge clock);
    rd(AJ, 8'h5a);
    rd(AH, 8'h00);
    boardEn <= 8'h00;
    setMode(2'b10);
    rd(AJ, 8'hff);
    rd(AG, 8'hff);
    $display("Test output and float done");
    wr(AH, 8'h80);
    rst_n <= 1'b0;
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    setMode(2'b00);
    rd(AJ, 8'h00);
    rd(AH, 8'h00);
    $display("Test second reset done");
    finalReport;
  end
endmodule
